// File: pkg/swn_pkg.sv
// Shared constants and types for the serial word memory port.
package swn_pkg;

  localparam int SWN_WORD_W = 14;
  localparam int SWN_WORDS = 50;
  localparam int SWN_DIGIT_W = 10;
  localparam int SWN_ADDR_BITS = 2 * SWN_DIGIT_W;
  localparam int SWN_IDX_W = 6;

  // Mode code order is {mode_line_a, mode_line_b, mode_line_c}.
  typedef enum logic [2:0] {
    SWN_ACC_DATA = 3'h0,
    SWN_WRITE = 3'h1,
    SWN_SHOUT = 3'h2,
    SWN_READ = 3'h3,
    SWN_ACC_ADDR = 3'h4,
    SWN_ERASE = 3'h5,
    SWN_UNUSED = 3'h6,
    SWN_STANDBY = 3'h7
  } swn_mode_t;

  typedef enum logic [1:0] {
    SWN_OP_READ = 2'h0,
    SWN_OP_WRITE = 2'h1,
    SWN_OP_ERASE = 2'h2
  } swn_op_t;

  typedef enum logic [6:0] {
    SWN_H_IDLE = 7'h01,
    SWN_H_ADDR = 7'h02,
    SWN_H_CLEAR = 7'h04,
    SWN_H_DATA = 7'h08,
    SWN_H_PROG = 7'h10,
    SWN_H_FETCH = 7'h20,
    SWN_H_SHOUT = 7'h40
  } swn_hstate_t;

  localparam int SWN_CLK_NS = 20;
  localparam int SWN_LINK_HZ = 14000;
  localparam int SWN_LINK_DIV = 1000000000 / (SWN_CLK_NS * SWN_LINK_HZ);
  localparam int SWN_LINK_LOW_PCT = 50;
  localparam int SWN_PROG_MS = 20;
  localparam int SWN_CLEAR_MS = 20;
  localparam int SWN_PROG_CYC = SWN_PROG_MS * 1000000 / SWN_CLK_NS;
  localparam int SWN_CLEAR_CYC = SWN_CLEAR_MS * 1000000 / SWN_CLK_NS;
  localparam int SWN_ACCESS_US = 20;
  localparam int SWN_ACCESS_CYC = SWN_ACCESS_US * 1000 / SWN_CLK_NS;

endpackage

// File: pkg/swn_link_if.sv
// Link between the memory device end and the controller end.
`timescale 1ns/10ps
interface swn_link_if;
  logic link_clk;
  logic mode_line_a;
  logic mode_line_b;
  logic mode_line_c;
  logic host_dout;
  logic host_oe_b;
  logic dev_dout;
  logic dev_oe_b;
  logic pin;

  // Undriven pin is pulled high.
  assign pin = !dev_oe_b ? dev_dout : (!host_oe_b ? host_dout : 1'b1);

  modport host (
    output link_clk,
    output mode_line_a,
    output mode_line_b,
    output mode_line_c,
    output host_dout,
    output host_oe_b,
    input pin
  );

  modport dev (
    input link_clk,
    input mode_line_a,
    input mode_line_b,
    input mode_line_c,
    output dev_dout,
    output dev_oe_b,
    input pin
  );
endinterface

// File: design/swn_device.sv
// Memory device end: mode decode, address and data shifters, word array.
`timescale 1ns/10ps
module swn_device
  import swn_pkg::*;
#(
  parameter int WORDS_P = SWN_WORDS
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  swn_link_if.dev link,
  output swn_mode_t mode_seen,
  output logic addr_ok,
  output logic [SWN_IDX_W-1:0] word_index,
  output logic [SWN_WORD_W-1:0] data_view
);

  // The word index is only SWN_IDX_W bits wide, so larger arrays cannot be reached.
  if (WORDS_P < 1 || WORDS_P > 2 ** SWN_IDX_W) begin : g_bad_words
    $error("WORDS_P must fit the word index.");
  end

  localparam logic [SWN_IDX_W:0] WORDS_L = (SWN_IDX_W + 1)'(WORDS_P);

  swn_mode_t mode;
  logic lclk_q;
  logic rise;
  logic [SWN_ADDR_BITS-1:0] addr_sr;
  logic [SWN_WORD_W-1:0] data_reg;
  logic [SWN_WORD_W-1:0] mem [WORDS_P];
  logic [3:0] tens;
  logic [3:0] units;
  logic [SWN_IDX_W:0] idx_full;
  logic [SWN_IDX_W-1:0] idx;
  logic idx_ok;

  // Converts a one-of-ten digit to its value.
  function automatic logic [3:0] digit_of(input logic [SWN_DIGIT_W-1:0] v);
    logic [3:0] d;
    d = 4'h0;
    for (int k = 0; k < SWN_DIGIT_W; k++) begin
      if (v[k]) begin
        d = 4'(k);
      end
    end
    return d;
  endfunction

  assign mode = swn_mode_t'({link.mode_line_a, link.mode_line_b, link.mode_line_c});

  // Inputs are synchronous to clk_sys, so one stage suffices for edges.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lclk_q <= 1'b1;
    end else if (ce) begin
      lclk_q <= link.link_clk;
    end
  end

  // Each link clock pulse acts once, at its rising edge, where the
  // controller guarantees stable mode and serial data.
  assign rise = link.link_clk && !lclk_q;

  // The tens digit occupies the upper ten bits after twenty pulses.
  always_comb begin
    tens = digit_of(addr_sr[SWN_ADDR_BITS-1:SWN_DIGIT_W]);
    units = digit_of(addr_sr[SWN_DIGIT_W-1:0]);
    idx_full = {tens, 3'h0} + {2'h0, tens, 1'h0} + {3'h0, units};
    idx = idx_full[SWN_IDX_W-1:0];
    idx_ok = $onehot(addr_sr[SWN_ADDR_BITS-1:SWN_DIGIT_W])
             && $onehot(addr_sr[SWN_DIGIT_W-1:0])
             && (idx_full < WORDS_L);
  end

  // Address register: changes only in accept address mode.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      addr_sr <= '0;
    end else if (ce) begin
      if (rise && mode == SWN_ACC_ADDR) begin
        addr_sr <= {addr_sr[SWN_ADDR_BITS-2:0], link.pin};
      end
    end
  end

  // Data register: loaded by read, shifted in by accept data, rotated by
  // shift output so fourteen pulses leave it as it was.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      data_reg <= '0;
    end else if (ce && rise) begin
      unique case (mode)
        SWN_ACC_DATA: begin
          data_reg <= {data_reg[SWN_WORD_W-2:0], link.pin};
        end
        SWN_SHOUT: begin
          data_reg <= {data_reg[SWN_WORD_W-2:0], data_reg[SWN_WORD_W-1]};
        end
        SWN_READ: begin
          // An address outside the array reads as all zeros.
          data_reg <= idx_ok ? mem[idx] : '0;
        end
        SWN_STANDBY, SWN_UNUSED, SWN_ERASE, SWN_ACC_ADDR, SWN_WRITE: begin
          data_reg <= data_reg;
        end
      endcase
    end
  end

  // Word array. Reset clears it because the flops cannot keep charge
  // across power like the real cells; a model of retention is left out.
  for (genvar w = 0; w < WORDS_P; w++) begin : g_word
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        mem[w] <= '0;
      end else if (ce && rise && idx_ok && idx == SWN_IDX_W'(w)) begin
        if (mode == SWN_ERASE) begin
          mem[w] <= '0;
        end else if (mode == SWN_WRITE) begin
          mem[w] <= data_reg;
        end
      end
    end
  end

  // Pin driver. The first bit appears one cycle after entering shift
  // output, far inside the access time; later bits two cycles after a rise.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      link.dev_oe_b <= 1'b1;
      link.dev_dout <= 1'b0;
    end else if (ce) begin
      link.dev_oe_b <= (mode != SWN_SHOUT);
      link.dev_dout <= data_reg[SWN_WORD_W-1];
    end
  end

  // Status seen by the local user.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_seen <= SWN_STANDBY;
      addr_ok <= 1'b0;
      word_index <= '0;
      data_view <= '0;
    end else if (ce) begin
      mode_seen <= mode;
      addr_ok <= idx_ok;
      word_index <= idx;
      data_view <= data_reg;
    end
  end

endmodule // swn_device

// File: design/swn_host.sv
// Controller end: clock divider and command sequencer driving the link.
`timescale 1ns/10ps
module swn_host
  import swn_pkg::*;
#(
  parameter int LINK_DIV_P = SWN_LINK_DIV,
  parameter int PROG_CYC_P = SWN_PROG_CYC,
  parameter int CLEAR_CYC_P = SWN_CLEAR_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  swn_link_if.host link,
  input wire logic cmd_valid,
  input wire swn_op_t cmd_op,
  input wire logic [SWN_IDX_W-1:0] cmd_addr,
  input wire logic [SWN_WORD_W-1:0] cmd_wdata,
  output logic busy,
  output logic done,
  output logic [SWN_WORD_W-1:0] rdata
);

  localparam int HIGH_C = LINK_DIV_P - LINK_DIV_P * SWN_LINK_LOW_PCT / 100;
  localparam int PROG_N = (PROG_CYC_P + LINK_DIV_P - 1) / LINK_DIV_P;
  localparam int CLEAR_N = (CLEAR_CYC_P + LINK_DIV_P - 1) / LINK_DIV_P;
  localparam int DW = $clog2(LINK_DIV_P + 1);
  localparam int LW = 20;

  if (LINK_DIV_P < 4 || HIGH_C < 2 || PROG_N >= 2 ** LW || CLEAR_N >= 2 ** LW
      || PROG_N < 1 || CLEAR_N < 1) begin : g_bad_timing
    $error("Link divider or interval parameters out of range.");
  end

  swn_hstate_t state;
  swn_op_t op;
  logic [DW-1:0] div_cnt;
  logic step;
  logic sample;
  logic pend;
  logic [LW-1:0] left;
  logic [SWN_ADDR_BITS-1:0] asr;
  logic [SWN_WORD_W-1:0] wsr;
  logic [SWN_WORD_W-1:0] rsr;
  logic [3:0] tens;
  logic [3:0] units;

  assign tens = 4'(cmd_addr / 6'd10);
  assign units = 4'(cmd_addr % 6'd10);

  // Divider with the low phase last; it runs in every mode.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= '0;
      link.link_clk <= 1'b1;
    end else if (ce) begin
      div_cnt <= (div_cnt == DW'(LINK_DIV_P - 1)) ? '0 : div_cnt + 1'b1;
      if (div_cnt == DW'(LINK_DIV_P - 1)) begin
        link.link_clk <= 1'b1;
      end else if (div_cnt == DW'(HIGH_C - 1)) begin
        link.link_clk <= 1'b0;
      end
    end
  end

  // Changes are made one cycle after the rise, sampling the cycle before it.
  assign step = (div_cnt == '0) && link.link_clk;
  assign sample = (div_cnt == DW'(LINK_DIV_P - 1));

  // Captures shifted-out bits just before each rising edge.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rsr <= '0;
    end else if (ce && sample && state == SWN_H_SHOUT) begin
      rsr <= {rsr[SWN_WORD_W-2:0], link.pin};
    end
  end

  // Sequencer: one link mode per state, each held for a count of pulses.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= SWN_H_IDLE;
      op <= SWN_OP_READ;
      pend <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      left <= '0;
      asr <= '0;
      wsr <= '0;
      rdata <= '0;
      {link.mode_line_a, link.mode_line_b, link.mode_line_c} <= SWN_STANDBY;
      link.host_oe_b <= 1'b1;
      link.host_dout <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      // Addresses past the array are ignored without raising busy.
      if (!busy && cmd_valid && cmd_addr < SWN_IDX_W'(SWN_WORDS)) begin
        pend <= 1'b1;
        busy <= 1'b1;
        op <= cmd_op;
        asr <= {SWN_DIGIT_W'(1) << tens, SWN_DIGIT_W'(1) << units};
        wsr <= cmd_wdata;
      end else if (step) begin
        unique case (state)
          SWN_H_IDLE: begin
            if (pend) begin
              pend <= 1'b0;
              state <= SWN_H_ADDR;
              {link.mode_line_a, link.mode_line_b, link.mode_line_c} <= SWN_ACC_ADDR;
              left <= LW'(SWN_ADDR_BITS);
              link.host_oe_b <= 1'b0;
              link.host_dout <= asr[SWN_ADDR_BITS-1];
              asr <= {asr[SWN_ADDR_BITS-2:0], 1'b0};
            end
          end
          SWN_H_ADDR: begin
            if (left == LW'(1)) begin
              link.host_oe_b <= 1'b1;
              if (op == SWN_OP_READ) begin
                state <= SWN_H_FETCH;
                {link.mode_line_a, link.mode_line_b, link.mode_line_c} <= SWN_READ;
                left <= LW'(1);
              end else begin
                state <= SWN_H_CLEAR;
                {link.mode_line_a, link.mode_line_b, link.mode_line_c} <= SWN_ERASE;
                left <= LW'(CLEAR_N);
              end
            end else begin
              left <= left - 1'b1;
              link.host_dout <= asr[SWN_ADDR_BITS-1];
              asr <= {asr[SWN_ADDR_BITS-2:0], 1'b0};
            end
          end
          SWN_H_CLEAR: begin
            if (left == LW'(1) && op == SWN_OP_WRITE) begin
              state <= SWN_H_DATA;
              {link.mode_line_a, link.mode_line_b, link.mode_line_c} <= SWN_ACC_DATA;
              left <= LW'(SWN_WORD_W);
              link.host_oe_b <= 1'b0;
              link.host_dout <= wsr[SWN_WORD_W-1];
              wsr <= {wsr[SWN_WORD_W-2:0], 1'b0};
            end else if (left == LW'(1)) begin
              state <= SWN_H_IDLE;
              {link.mode_line_a, link.mode_line_b, link.mode_line_c} <= SWN_STANDBY;
              busy <= 1'b0;
              done <= 1'b1;
            end else begin
              left <= left - 1'b1;
            end
          end
          SWN_H_DATA: begin
            if (left == LW'(1)) begin
              state <= SWN_H_PROG;
              {link.mode_line_a, link.mode_line_b, link.mode_line_c} <= SWN_WRITE;
              left <= LW'(PROG_N);
              link.host_oe_b <= 1'b1;
            end else begin
              left <= left - 1'b1;
              link.host_dout <= wsr[SWN_WORD_W-1];
              wsr <= {wsr[SWN_WORD_W-2:0], 1'b0};
            end
          end
          SWN_H_FETCH: begin
            state <= SWN_H_SHOUT;
            {link.mode_line_a, link.mode_line_b, link.mode_line_c} <= SWN_SHOUT;
            left <= LW'(SWN_WORD_W);
          end
          SWN_H_PROG, SWN_H_SHOUT: begin
            if (left == LW'(1)) begin
              state <= SWN_H_IDLE;
              {link.mode_line_a, link.mode_line_b, link.mode_line_c} <= SWN_STANDBY;
              busy <= 1'b0;
              done <= 1'b1;
              if (state == SWN_H_SHOUT) begin
                rdata <= rsr;
              end
            end else begin
              left <= left - 1'b1;
            end
          end
          default: begin
            state <= SWN_H_IDLE;
            {link.mode_line_a, link.mode_line_b, link.mode_line_c} <= SWN_STANDBY;
            link.host_oe_b <= 1'b1;
            busy <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // swn_host

// File: tb/swn_properties.sv
// Link checks between the controller end and the memory device end.
`timescale 1ns/10ps
module swn_properties
  import swn_pkg::*;
#(
  parameter int LINK_DIV_P = SWN_LINK_DIV,
  parameter int PROG_CYC_P = SWN_PROG_CYC,
  parameter int CLEAR_CYC_P = SWN_CLEAR_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic mode_line_a,
  input wire logic mode_line_b,
  input wire logic mode_line_c,
  input wire logic host_dout,
  input wire logic host_oe_b,
  input wire logic dev_dout,
  input wire logic dev_oe_b,
  input wire logic pin
);
  logic [2:0] mode;
  logic [2:0] mode_prev;
  logic lclk_prev;
  logic started;
  logic [31:0] per_cnt;
  logic [31:0] run_cnt;
  logic [31:0] out_age;

  assign mode = {mode_line_a, mode_line_b, mode_line_c};

  // Period is counted from rise to rise; the first period after reset is skipped.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lclk_prev <= 1'b1;
      started <= 1'b0;
      per_cnt <= 32'h0;
    end else if (ce) begin
      lclk_prev <= link_clk;
      started <= started || (link_clk && !lclk_prev);
      per_cnt <= (link_clk && !lclk_prev) ? 32'h1 : per_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_prev <= 3'h7;
      run_cnt <= 32'h0;
      out_age <= 32'h0;
    end else if (ce) begin
      mode_prev <= mode;
      run_cnt <= (mode != mode_prev) ? 32'h1 : run_cnt + 32'h1;
      out_age <= ((link_clk && !lclk_prev) || mode != mode_prev) ? 32'h0 : out_age + 32'h1;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  // Both ends stop with the clock enable, so the counters and the checks stop too.
  default disable iff (!rst_b || !ce);

  sequence link_rise;
    link_clk && !lclk_prev ##0 started;
  endsequence

  sequence link_fall;
    !link_clk && lclk_prev ##0 started;
  endsequence

  sequence mode_leaves(logic [2:0] m);
    mode_prev == m && mode != m;
  endsequence

  unused_code_a: assert property (mode != 3'h6)
    else $error("unused mode code on the link");
  oe_follow_a: assert property (dev_oe_b == ($past(mode) != SWN_SHOUT))
    else $error("device pin enable does not follow shift-out mode");
  host_release_a: assert property (!host_oe_b |-> mode inside {SWN_ACC_ADDR, SWN_ACC_DATA})
    else $error("controller drives the pin outside accept modes");
  no_clash_a: assert property (host_oe_b || dev_oe_b)
    else $error("both ends drive the pin");
  mode_hold_a: assert property (mode != mode_prev |-> link_clk && lclk_prev)
    else $error("mode changed outside the clock high phase");
  din_hold_a: assert property (!host_oe_b && $changed(host_dout) |-> link_clk && lclk_prev)
    else $error("serial input changed outside the clock high phase");
  link_period_a: assert property (link_rise |-> per_cnt == LINK_DIV_P)
    else $error("link clock period wrong");
  link_low_a: assert property (link_fall |->
    per_cnt == LINK_DIV_P - LINK_DIV_P * SWN_LINK_LOW_PCT / 100)
    else $error("link clock low phase wrong");
  prog_hold_a: assert property (mode_leaves(SWN_WRITE) |->
    run_cnt >= PROG_CYC_P && run_cnt <= PROG_CYC_P * 6 / 5) else $error("write held wrongly");
  clear_hold_a: assert property (mode_leaves(SWN_ERASE) |->
    run_cnt >= CLEAR_CYC_P && run_cnt <= CLEAR_CYC_P * 6 / 5) else $error("erase held wrongly");
  addr_len_a: assert property (mode_leaves(SWN_ACC_ADDR) |-> run_cnt == 20 * LINK_DIV_P)
    else $error("address pass not twenty pulses");
  word_len_a: assert property (mode_leaves(SWN_ACC_DATA) |-> run_cnt == 14 * LINK_DIV_P)
    else $error("data pass not fourteen pulses");
  out_access_a: assert property ($changed(dev_dout) && !dev_oe_b && !$past(dev_oe_b) |->
    out_age < 2) else $error("output bit late after clock rise");
endmodule // swn_properties

// File: tb/serial_word_nvm_mode_port_test.sv
// Self-checking bench joining the controller and the memory device over the link.
`timescale 1ns/10ps
module serial_word_nvm_mode_port_test
  import swn_pkg::*;
();
  localparam int DIV = 8;
  localparam int LIMIT = 20000;
  logic clk_sys;
  logic rst_b;
  logic ce;
  logic cmd_valid;
  swn_op_t cmd_op;
  logic [SWN_IDX_W-1:0] cmd_addr;
  logic [SWN_WORD_W-1:0] cmd_wdata;
  logic busy, done, addr_ok;
  logic [SWN_WORD_W-1:0] rdata, data_view;
  logic [SWN_IDX_W-1:0] word_index;
  swn_mode_t mode_seen;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  logic prev_lclk = 1'b1;
  logic [3:0] trace[$];

  swn_link_if link();
  // Short program and clear counts keep each write near three hundred cycles.
  swn_host #(.LINK_DIV_P(DIV), .PROG_CYC_P(16), .CLEAR_CYC_P(16)) swn_host_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .link(link), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .busy(busy), .done(done),
    .rdata(rdata));
  swn_device swn_device_i (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .link(link),
    .mode_seen(mode_seen), .addr_ok(addr_ok), .word_index(word_index), .data_view(data_view));
  swn_properties #(.LINK_DIV_P(DIV), .PROG_CYC_P(16), .CLEAR_CYC_P(16)) swn_properties_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .link_clk(link.link_clk),
    .mode_line_a(link.mode_line_a), .mode_line_b(link.mode_line_b),
    .mode_line_c(link.mode_line_c), .host_dout(link.host_dout),
    .host_oe_b(link.host_oe_b), .dev_dout(link.dev_dout), .dev_oe_b(link.dev_oe_b),
    .pin(link.pin));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // The pin level at every link clock rise is what the receiving end takes.
  always @(posedge clk_sys) begin
    prev_lclk <= link.link_clk;
    if (link.link_clk && !prev_lclk) begin
      trace.push_back({link.mode_line_a, link.mode_line_b, link.mode_line_c, link.pin});
    end
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] stream(input logic [2:0] m);
    logic [31:0] v;
    v = 32'h0;
    foreach (trace[i]) begin
      if (trace[i][3:1] == m) begin
        v = {v[30:0], trace[i][0]};
      end
    end
    return v;
  endfunction

  function automatic logic [31:0] addr_bits(input logic [SWN_IDX_W-1:0] a);
    return {12'h000, 10'h001 << (a / 10), 10'h001 << (a % 10)};
  endfunction

  task automatic run(input swn_op_t op, input logic [SWN_IDX_W-1:0] a, input logic [13:0] d);
    int i;
    trace.delete();
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (i = 0; i < 1000 && done !== 1'b1; i++) @(negedge clk_sys);
    check(done, 1'b1);
  endtask

  task automatic t_reset();
    check(mode_seen, SWN_STANDBY);
    check(link.dev_oe_b, 1'b1);
    check(link.pin, 1'b1);
    check(data_view, 14'h0000);
  endtask

  task automatic t_write_read(input logic [SWN_IDX_W-1:0] a, input logic [13:0] d);
    run(SWN_OP_WRITE, a, d);
    check(stream(SWN_ACC_ADDR), addr_bits(a));
    check(stream(SWN_ACC_DATA), d);
    check(data_view, d);
    check(word_index, a);
    check(addr_ok, 1'b1);
    run(SWN_OP_READ, a, 14'h0000);
    check(rdata, d);
    check(stream(SWN_SHOUT), d);
    // The device status lags the link by one cycle, so let the standby code arrive.
    @(negedge clk_sys);
    check(mode_seen, SWN_STANDBY);
    check(link.dev_oe_b, 1'b1);
  endtask

  task automatic t_erase();
    run(SWN_OP_ERASE, 6'h0A, 14'h0000);
    check(data_view, 14'h0001);
    run(SWN_OP_READ, 6'h0A, 14'h0000);
    check(rdata, 14'h0000);
    run(SWN_OP_READ, 6'h09, 14'h0000);
    check(rdata, 14'h2AAA);
  endtask

  // An address past the array is dropped, and a request while busy is not queued.
  task automatic t_refuse();
    int i;
    cmd_addr = 6'h32;
    cmd_op = SWN_OP_READ;
    cmd_valid = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(busy, 1'b0);
    cmd_addr = 6'h31;
    @(negedge clk_sys);
    cmd_op = SWN_OP_WRITE;
    cmd_wdata = 14'h0000;
    repeat (3) @(negedge clk_sys);
    cmd_valid = 1'b0;
    for (i = 0; i < 1000 && done !== 1'b1; i++) @(negedge clk_sys);
    check(rdata, 14'h0001);
    repeat (4) @(negedge clk_sys);
    check(busy, 1'b0);
    run(SWN_OP_READ, 6'h31, 14'h0000);
    check(rdata, 14'h0001);
  endtask

  // A low clock enable holds both ends, and a command offered meanwhile is not taken.
  task automatic t_freeze();
    logic lclk_hold;
    repeat (2) @(negedge clk_sys);
    lclk_hold = link.link_clk;
    ce = 1'b0;
    cmd_op = SWN_OP_READ;
    cmd_addr = 6'h00;
    cmd_valid = 1'b1;
    repeat (20) @(negedge clk_sys);
    check(busy, 1'b0);
    check(link.link_clk, lclk_hold);
    check(mode_seen, SWN_STANDBY);
    check(data_view, 14'h0001);
    cmd_valid = 1'b0;
    ce = 1'b1;
    run(SWN_OP_READ, 6'h00, 14'h0000);
    check(rdata, 14'h3FFF);
  endtask

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = SWN_OP_READ;
    cmd_addr = 6'h00;
    cmd_wdata = 14'h0000;
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    t_reset();
    t_write_read(6'h00, 14'h3FFF);
    t_write_read(6'h09, 14'h2AAA);
    t_write_read(6'h31, 14'h0001);
    t_write_read(6'h0A, 14'h1555);
    run(SWN_OP_WRITE, 6'h31, 14'h0001);
    t_erase();
    t_refuse();
    t_freeze();
    end_of_test();
  end
endmodule // serial_word_nvm_mode_port_test
